// file: hdl/ppr_regulator.sv
// Purpose: PID position regulator producing a corrected velocity
// Assumes: Encoder, ramp position and ramp velocity are synchronous to clk
// Notes: Terms update once per 128 clocks; outputs settle three clocks after a tick
// Behaviour
// - P term: error times gain over 256
// - I term: sum/256 times gain over 256
// - D term: clipped error delta times gain
// - D sampling every 128 times divider clocks, a zero divider counting as 256
// - Integrator limited to clip times 65536
// - Integrator updates, readable, cleared by write
// - Velocity is ramp plus clipped result
// - Readable error is encoder minus ramp, saturated
// - Reported velocity bare or plus ramp
// - Dead band after exact hit zeroes regulator
`timescale 1ns/10ps

module ppr_regulator (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Host register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Motion inputs
    input wire logic [31:0] enc_pos,
    input wire logic [31:0] ramp_pos,
    input wire logic [31:0] ramp_vel,
    input wire logic vel_base_sel,
    // Regulated velocity to the step generator
    output logic [31:0] vel_cmd
);
    import ppr_pkg::*;

    // Clamp a wide signed value into plus or minus lim
    function automatic logic signed [63:0] clip64(input logic signed [63:0] v,
                                                  input logic signed [63:0] lim);
        if (v > lim) begin
            clip64 = lim;
        end else if (v < -lim) begin
            clip64 = -lim;
        end else begin
            clip64 = v;
        end
    endfunction : clip64

    // Magnitude of a wide signed value
    function automatic logic signed [63:0] abs64(input logic signed [63:0] v);
        abs64 = (v < 0) ? -v : v;
    endfunction : abs64

    // Host writable settings
    logic [PPR_GAIN_W-1:0] prop_gain_r; // Proportional gain
    logic [PPR_GAIN_W-1:0] int_gain_r; // Integral gain
    logic [PPR_GAIN_W-1:0] der_gain_r; // Derivative gain
    logic [PPR_ICLIP_W-1:0] int_limit_r; // Integrator clip
    logic [PPR_DDIV_W-1:0] der_div_r; // Derivative rate divider
    logic [PPR_DVCLIP_W-1:PPR_DVCLIP_LSB] dv_limit_r; // Correction clip, low bits zero
    logic [PPR_TOL_W-1:0] dead_band_r; // Error tolerance
    // Regulator state
    logic signed [31:0] isum_r; // Integrator sum
    logic signed [PPR_ERR_W-1:0] pos_err_r; // Saturated error for readback
    logic signed [PPR_ERR_W-1:0] der_last_r; // Last derivative sample
    logic signed [7:0] der_delta_r; // Clipped error difference
    logic signed [PPR_ERR_W-1:0] fed_err_r; // Error fed to the regulator on the last tick
    logic signed [31:0] p_term_r; // Proportional contribution
    logic signed [31:0] i_term_r; // Integral contribution
    logic signed [31:0] d_term_r; // Derivative contribution
    logic signed [34:0] sum_r; // Combined result before clip
    logic signed [31:0] corr_r; // Clipped correction
    logic signed [31:0] read_vel_r; // Reported regulated velocity
    logic in_band_r; // Dead band latched after exact hit
    // Timing
    logic [6:0] tick_cnt_r; // Divides clk by 128
    logic [8:0] der_cnt_r; // Counts ticks between derivative samples
    logic tick_d_r; // Tick delayed one clock
    logic tick_dd_r; // Tick delayed two clocks
    logic [31:0] rdata_r; // Read data flop
    logic signed [31:0] vel_cmd_r; // Velocity command flop

    // Combinational helpers
    logic tick;
    logic der_sample;
    logic [8:0] der_len;
    logic signed [63:0] err_raw;
    logic signed [63:0] err_sat;
    logic in_band_nxt;
    logic signed [63:0] err_in;
    logic signed [63:0] der_delta_nxt;
    logic signed [63:0] isum_nxt;
    logic signed [63:0] corr_nxt;
    logic isum_wr;
    logic signed [63:0] p_prod; // Clipped proportional product
    logic signed [63:0] i_prod; // Clipped integral product
    logic signed [63:0] d_prod; // Clipped derivative product
    logic signed [63:0] vel_sum_nxt; // Correction plus ramp velocity, saturated

    assign tick = (tick_cnt_r == PPR_TICK_LAST);
    assign der_len = (der_div_r == '0) ? PPR_DDIV_ZERO : {1'b0, der_div_r};
    assign der_sample = tick && (der_cnt_r >= der_len - 9'h001);
    assign isum_wr = reg_wr_en && (reg_addr == PPR_IDX_ISUM);
    assign err_raw = $signed({{32{enc_pos[31]}}, enc_pos}) -
                     $signed({{32{ramp_pos[31]}}, ramp_pos});
    assign err_sat = clip64(err_raw, PPR_SAT_ERR);

    // Dead band: entered on an exact hit, left once the error reaches tolerance
    always_comb begin
        if (err_sat == 64'sh0) begin
            in_band_nxt = 1'b1;
        end else if (abs64(err_sat) >= $signed({44'h0, dead_band_r})) begin
            in_band_nxt = 1'b0;
        end else begin
            in_band_nxt = in_band_r;
        end
        err_in = in_band_nxt ? 64'sh0 : err_sat;
        der_delta_nxt = clip64($signed({{40{der_last_r[PPR_ERR_W-1]}}, der_last_r}) - err_in,
                               PPR_SAT_DDELTA);
        isum_nxt = clip64($signed({{32{isum_r[31]}}, isum_r}) + err_in,
                          $signed({33'h0, int_limit_r, 16'h0}));
        corr_nxt = clip64($signed({{29{sum_r[34]}}, sum_r}),
                          $signed({33'h0, dv_limit_r, 8'h0}));
    end

    // Compute clock divider and delayed strobes
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_r <= '0;
            tick_d_r <= 1'b0;
            tick_dd_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 7'h01;
            tick_d_r <= tick;
            tick_dd_r <= tick_d_r;
        end
    end

    // Host writes to settings
    always_ff @(posedge clk) begin
        if (srst) begin
            prop_gain_r <= '0;
            int_gain_r <= '0;
            der_gain_r <= '0;
            int_limit_r <= '0;
            der_div_r <= '0;
            dv_limit_r <= '0;
            dead_band_r <= '0;
        end else if (reg_wr_en) begin
            case (reg_addr)
                PPR_IDX_PGAIN: prop_gain_r <= reg_wdata[PPR_GAIN_W-1:0];
                PPR_IDX_IGAIN: int_gain_r <= reg_wdata[PPR_GAIN_W-1:0];
                PPR_IDX_DGAIN: der_gain_r <= reg_wdata[PPR_GAIN_W-1:0];
                PPR_IDX_ICLIP: int_limit_r <= reg_wdata[PPR_ICLIP_W-1:0];
                PPR_IDX_DDIV: der_div_r <= reg_wdata[PPR_DDIV_W-1:0];
                // Low eight bits are dropped so they always read as zero
                PPR_IDX_DVCLIP: dv_limit_r <= reg_wdata[PPR_DVCLIP_W-1:PPR_DVCLIP_LSB];
                PPR_IDX_TOL: dead_band_r <= reg_wdata[PPR_TOL_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Error, dead band and integrator, once per tick; integrator also cleared by a host write in any cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pos_err_r <= '0;
            in_band_r <= 1'b0;
            isum_r <= '0;
        end else begin
            if (tick) begin
                pos_err_r <= err_sat[PPR_ERR_W-1:0];
                in_band_r <= in_band_nxt;
            end
            // A host write beats a same-cycle update: the write is the clear
            if (isum_wr) begin
                isum_r <= '0;
            end else if (tick && in_band_nxt) begin
                isum_r <= '0;
            end else if (tick) begin
                isum_r <= isum_nxt[31:0];
            end
        end
    end

    // Derivative sampling counter and delta
    always_ff @(posedge clk) begin
        if (srst) begin
            der_cnt_r <= '0;
            der_last_r <= '0;
            der_delta_r <= '0;
        end else if (der_sample) begin
            der_cnt_r <= '0;
            der_last_r <= err_in[PPR_ERR_W-1:0];
            der_delta_r <= der_delta_nxt[7:0];
        end else if (tick) begin
            der_cnt_r <= der_cnt_r + 9'h001;
        end
    end

    // Term products, clipped before registering; a zero gain gives a zero term
    assign p_prod = clip64(($signed({{40{fed_err_r[PPR_ERR_W-1]}}, fed_err_r}) *
                            $signed({40'h0, prop_gain_r})) >>> PPR_GAIN_SHIFT, PPR_SAT32);
    assign i_prod = clip64((($signed({{32{isum_r[31]}}, isum_r}) >>> PPR_GAIN_SHIFT) *
                            $signed({40'h0, int_gain_r})) >>> PPR_GAIN_SHIFT, PPR_SAT32);
    assign d_prod = clip64($signed({{56{der_delta_r[7]}}, der_delta_r}) *
                           $signed({40'h0, der_gain_r}), PPR_SAT32);

    // Term registers, loaded one clock after the tick
    always_ff @(posedge clk) begin
        if (srst) begin
            p_term_r <= '0;
            i_term_r <= '0;
            d_term_r <= '0;
        end else if (tick_d_r) begin
            p_term_r <= p_prod[31:0];
            i_term_r <= i_prod[31:0];
            d_term_r <= d_prod[31:0];
        end
    end

    // Error that was fed to the regulator on the last tick
    always_ff @(posedge clk) begin
        if (srst) begin
            fed_err_r <= '0;
        end else if (tick) begin
            fed_err_r <= err_in[PPR_ERR_W-1:0];
        end
    end

    // Sum of terms, then clipped correction and output velocities
    always_ff @(posedge clk) begin
        if (srst) begin
            sum_r <= '0;
        end else if (tick_dd_r) begin
            sum_r <= 35'(p_term_r) + 35'(i_term_r) + 35'(d_term_r);
        end
    end

    // Correction plus ramp velocity, held to the 32-bit range
    assign vel_sum_nxt = clip64(corr_nxt + $signed({{32{ramp_vel[31]}}, ramp_vel}),
                                PPR_SAT32);

    logic tick_ddd_r; // Strobe for the clipped stage
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_ddd_r <= 1'b0;
            corr_r <= '0;
            read_vel_r <= '0;
            vel_cmd_r <= '0;
        end else begin
            tick_ddd_r <= tick_dd_r;
            if (tick_ddd_r) begin
                corr_r <= corr_nxt[31:0];
                read_vel_r <= vel_base_sel ? vel_sum_nxt[31:0] : corr_nxt[31:0];
                vel_cmd_r <= vel_sum_nxt[31:0];
            end
        end
    end

    // Register read: only readback registers answer, others read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= PPR_RST_WORD;
        end else if (reg_rd_en) begin
            case (reg_addr)
                PPR_IDX_ISUM: rdata_r <= isum_r;
                PPR_IDX_ERR: rdata_r <= {{8{pos_err_r[PPR_ERR_W-1]}}, pos_err_r};
                PPR_IDX_VREAD: rdata_r <= read_vel_r;
                default: rdata_r <= PPR_RST_WORD;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign vel_cmd = vel_cmd_r;

    // Checks
    tick_period_a: assert property (@(posedge clk) disable iff (srst)
        tick |=> !tick ##127 tick) else $error("compute tick not every 128 clocks");
    p_zero_a: assert property (@(posedge clk) disable iff (srst)
        ($past(tick_d_r) && prop_gain_r == '0 && $past(prop_gain_r) == '0) |-> p_term_r == 0)
        else $error("P term not disabled by zero gain");
    i_zero_a: assert property (@(posedge clk) disable iff (srst)
        ($past(tick_d_r) && $past(int_gain_r) == '0) |-> i_term_r == 0)
        else $error("I term not disabled by zero gain");
    d_delta_a: assert property (@(posedge clk) disable iff (srst)
        der_delta_r <= 8'sd127 && der_delta_r >= -8'sd127)
        else $error("derivative delta out of range");
    d_on_tick_a: assert property (@(posedge clk) disable iff (srst)
        (der_sample && der_div_r == 8'h01) |-> ##128 (der_sample || der_div_r != 8'h01))
        else $error("derivative sample spacing wrong");
    isum_lim_a: assert property (@(posedge clk) disable iff (srst)
        (tick && !isum_wr && !in_band_nxt) |=>
        abs64($signed({{32{isum_r[31]}}, isum_r})) <= $signed({33'h0, $past(int_limit_r), 16'h0}))
        else $error("integrator exceeds clip");
    isum_clr_a: assert property (@(posedge clk) disable iff (srst)
        isum_wr |=> isum_r == 0) else $error("integrator not cleared by write");
    dv_off_a: assert property (@(posedge clk) disable iff (srst)
        (tick_ddd_r && dv_limit_r == '0) |=> corr_r == 0)
        else $error("zero clip does not disable correction");
    err_sat_a: assert property (@(posedge clk) disable iff (srst)
        (tick && err_raw > PPR_SAT_ERR) |=> pos_err_r == 24'sh7fffff)
        else $error("error not saturated");
    vel_base_a: assert property (@(posedge clk) disable iff (srst)
        ($past(tick_ddd_r) && !$past(vel_base_sel)) |-> read_vel_r == corr_r)
        else $error("bare result not reported");
    band_a: assert property (@(posedge clk) disable iff (srst)
        (tick && in_band_nxt) |=> (isum_r == 0 && fed_err_r == 0))
        else $error("dead band not zeroing regulator");
    sum_a: assert property (@(posedge clk) disable iff (srst)
        tick_dd_r |=> sum_r == 35'($past(p_term_r)) + 35'($past(i_term_r)) + 35'($past(d_term_r)))
        else $error("sum of terms wrong");
endmodule : ppr_regulator

// file: hdl/ppr_pkg.sv
// Purpose: Constants shared by the position regulator and its bench
// Assumes: Register indices are word indices on the host register port
// Notes: Byte address of a register is four times its index

package ppr_pkg;
    // Register indices
    localparam logic [6:0] PPR_IDX_PGAIN = 7'h20;
    localparam logic [6:0] PPR_IDX_IGAIN = 7'h21;
    localparam logic [6:0] PPR_IDX_DGAIN = 7'h22;
    localparam logic [6:0] PPR_IDX_ICLIP = 7'h23;
    localparam logic [6:0] PPR_IDX_ISUM = 7'h24;
    localparam logic [6:0] PPR_IDX_DDIV = 7'h25;
    localparam logic [6:0] PPR_IDX_DVCLIP = 7'h27;
    localparam logic [6:0] PPR_IDX_ERR = 7'h28;
    localparam logic [6:0] PPR_IDX_VREAD = 7'h29;
    localparam logic [6:0] PPR_IDX_TOL = 7'h2a;
    // Field widths
    localparam int PPR_GAIN_W = 24;
    localparam int PPR_ICLIP_W = 15;
    localparam int PPR_DDIV_W = 8;
    localparam int PPR_DVCLIP_LSB = 8;
    localparam int PPR_DVCLIP_W = 31;
    localparam int PPR_ERR_W = 24;
    localparam int PPR_TOL_W = 20;
    localparam int PPR_ISUM_SHIFT = 16;
    localparam int PPR_GAIN_SHIFT = 8;
    // Reset values
    localparam logic [31:0] PPR_RST_WORD = 32'h0000_0000;
    // Timing: last count of the 128-clock compute period, and derivative divider zero meaning
    localparam logic [6:0] PPR_TICK_LAST = 7'h7f;
    localparam logic [8:0] PPR_DDIV_ZERO = 9'h100;
    // Saturation limits
    localparam logic signed [63:0] PPR_SAT32 = 64'sh0000_0000_7fff_ffff;
    localparam logic signed [63:0] PPR_SAT_ERR = 64'sh0000_0000_007f_ffff;
    localparam logic signed [63:0] PPR_SAT_DDELTA = 64'sh0000_0000_0000_007f;
endpackage : ppr_pkg

// file: verif/ppr_host.sv
// Purpose: Host processor model driving the regulator register port
// Assumes: Strobes change only just after a rising clock edge
// Notes: Released address and data lines carry the inverse of the last value
`timescale 1ns/10ps

module ppr_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [6:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    // Idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 32'h0000_0000;
    end

    // One write; stale lines are scrambled so nothing leans on them
    task automatic write_reg(input logic [6:0] addr, input logic [31:0] data);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask : write_reg

    // One read; data is taken once the flop has loaded
    task automatic read_reg(input logic [6:0] addr, output logic [31:0] data);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~addr;
        @(posedge clk);
        data = reg_rdata;
    endtask : read_reg
endmodule : ppr_host

// file: verif/position_pid_regulator_test.sv
// Purpose: Self-checking bench for the position regulator
// Assumes: Compute ticks every 128 clocks counted from reset release
// Notes: The zero divider case alone takes about 66k clocks
`timescale 1ns/10ps

module position_pid_regulator_test;
    import ppr_pkg::*;
    // Design hookup
    logic clk, srst, reg_wr_en, reg_rd_en, vel_base_sel;
    logic [6:0] reg_addr, ph;
    logic [31:0] reg_wdata, reg_rdata, enc_pos, ramp_pos, ramp_vel, vel_cmd;
    // Scoreboard
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // Error saturation table: encoder, ramp, expected error
    logic [31:0] e_tab[3] = '{32'h0100_0000, 32'h0, 32'h0000_03e8};
    logic [31:0] r_tab[3] = '{32'h0, 32'h0100_0000, 32'hffff_fe0c};
    logic [31:0] x_tab[3] = '{32'h007f_ffff, 32'hff80_0001, 32'h0000_05dc};
    // Dead band walk and derivative divider tables
    logic [31:0] db_e[4] = '{32'd0, 32'd300, 32'd600, 32'd300};
    logic [31:0] db_x[4] = '{32'd0, 32'd0, 32'd600, 32'd300};
    logic [7:0] dv_tab[3] = '{8'h01, 8'h03, 8'h00};
    int dn_tab[3] = '{1, 3, 256};
    logic [31:0] dx_tab[3] = '{32'hffff_fffe, 32'hffff_fffa, 32'hffff_ff02};

    ppr_regulator u_ppr_regulator (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .enc_pos(enc_pos), .ramp_pos(ramp_pos),
        .ramp_vel(ramp_vel), .vel_base_sel(vel_base_sel), .vel_cmd(vel_cmd));
    ppr_host u_ppr_host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Tick phase mirror, plus a hang limit above the expected 72k clocks
    always @(posedge clk) begin
        ph <= srst ? 7'h00 : ph + 7'h01;
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic rd_chk(input logic [6:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        u_ppr_host.read_reg(addr, d);
        check32(d, exp);
    endtask : rd_chk

    task automatic wr(input logic [6:0] addr, input logic [31:0] data);
        u_ppr_host.write_reg(addr, data);
    endtask : wr

    // Ends n ticks on, well after the last tick's outputs settled
    task automatic settle(input int n);
        repeat (n) begin
            @(posedge clk);
            while (ph != 7'h14) @(posedge clk);
        end
    endtask : settle

    task automatic motion(input logic [31:0] e, input logic [31:0] r, input logic [31:0] v);
        enc_pos <= e;
        ramp_pos <= r;
        ramp_vel <= v;
    endtask : motion

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        srst = 1'b1;
        vel_base_sel = 1'b0;
        enc_pos = 32'h0;
        ramp_pos = 32'h0;
        ramp_vel = 32'h0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        // Reset state; write-only, unmapped and read-only places
        rd_chk(PPR_IDX_ISUM, 32'h0);
        rd_chk(PPR_IDX_PGAIN, 32'h0);
        rd_chk(7'h26, 32'h0);
        wr(PPR_IDX_ERR, 32'h0000_1234);
        settle(2);
        rd_chk(PPR_IDX_ERR, 32'h0);
        check32(vel_cmd, 32'h0);
        $display("test reset done");
        // Error saturation at both ends and in range
        wr(PPR_IDX_DVCLIP, 32'h7fff_ffff);
        for (int i = 0; i < 3; i++) begin
            motion(e_tab[i], r_tab[i], 32'h0);
            settle(2);
            rd_chk(PPR_IDX_ERR, x_tab[i]);
        end
        $display("test error done");
        // Proportional path, base select and velocity clip
        wr(PPR_IDX_PGAIN, 32'h0000_0200);
        motion(32'd1000, 32'd0, 32'd100);
        settle(2);
        rd_chk(PPR_IDX_VREAD, 32'd2000);
        check32(vel_cmd, 32'd2100);
        vel_base_sel <= 1'b1;
        settle(2);
        rd_chk(PPR_IDX_VREAD, 32'd2100);
        wr(PPR_IDX_DVCLIP, 32'h0000_05ff);
        settle(2);
        rd_chk(PPR_IDX_VREAD, 32'd1380);
        wr(PPR_IDX_DVCLIP, 32'h0000_00ff);
        settle(2);
        check32(vel_cmd, 32'd100);
        wr(PPR_IDX_DVCLIP, 32'h7fff_ffff);
        wr(PPR_IDX_PGAIN, 32'h00ff_ffff);
        motion(32'h0100_0000, 32'h0, 32'h0000_0100);
        settle(2);
        rd_chk(PPR_IDX_VREAD, 32'h7fff_ffff);
        check32(vel_cmd, 32'h7fff_ffff);
        vel_base_sel <= 1'b0;
        settle(2);
        rd_chk(PPR_IDX_VREAD, 32'h7fff_ff00);
        $display("test proportional done");
        // Integrator clip, term, clear on write, negative side
        wr(PPR_IDX_PGAIN, 32'h0);
        wr(PPR_IDX_IGAIN, 32'h0000_0200);
        wr(PPR_IDX_ICLIP, 32'h0000_0001);
        motion(32'd30000, 32'd0, 32'd0);
        settle(4);
        rd_chk(PPR_IDX_ISUM, 32'h0001_0000);
        rd_chk(PPR_IDX_VREAD, 32'd512);
        wr(PPR_IDX_ISUM, 32'h1234_5678);
        rd_chk(PPR_IDX_ISUM, 32'h0);
        motion(32'hffff_8ad0, 32'd0, 32'd0);
        settle(5);
        rd_chk(PPR_IDX_ISUM, 32'hffff_0000);
        rd_chk(PPR_IDX_VREAD, 32'hffff_fe00);
        $display("test integral done");
        // Dead band after an exact hit, left only at or past the tolerance
        wr(PPR_IDX_ICLIP, 32'h0);
        wr(PPR_IDX_IGAIN, 32'h0);
        wr(PPR_IDX_PGAIN, 32'h0000_0100);
        wr(PPR_IDX_TOL, 32'h0000_01f4);
        for (int i = 0; i < 4; i++) begin
            motion(db_e[i], 32'h0, 32'h0);
            settle(2);
            check32(vel_cmd, db_x[i]);
        end
        $display("test dead band done");
        // Derivative on an error ramp of one count per tick
        wr(PPR_IDX_TOL, 32'h0);
        wr(PPR_IDX_PGAIN, 32'h0);
        wr(PPR_IDX_DGAIN, 32'h0000_0002);
        for (int i = 0; i < 3; i++) begin
            wr(PPR_IDX_DDIV, {24'h0, dv_tab[i]});
            repeat (2 * dn_tab[i] + 2) begin
                settle(1);
                enc_pos <= enc_pos + 32'd1;
            end
            settle(1);
            check32(vel_cmd, dx_tab[i]);
        end
        $display("test derivative done");
        print_verdict();
    end
endmodule : position_pid_regulator_test
